/* rtl/qsmc_core.sv */
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module qsmc_core
  import qsmc_pkg::*;
#(
  parameter int POST_ZERO = POST_ZERO_CYCLES
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic serialClock,
  output logic serialOut,
  output logic serialOutEn_n,
  input wire logic serialIn,
  output logic [3:0] chipSelect
);

  localparam logic [13:0] POST_ZERO_W = 14'(POST_ZERO);

  qsmc_mode_t mode_r;
  qsmc_delay_t delay_r;
  qsmc_wrap_t wrap_r;
  logic finished_r;
  logic aborted_r;
  logic lockout_r;
  logic [5:0] ramAddr_r;
  logic [15:0] txRam [16];
  logic [15:0] rxRam [16];
  qsmc_cmd_t cmdRam [16];

  logic pend_r;
  logic pendWrite_r;
  logic [11:0] pendAddr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  qsmc_state_t state_r;
  logic [3:0] workPtr_r;
  qsmc_cmd_t cmd_r;
  logic [4:0] bits_r;
  logic [4:0] edgeCnt_r;
  logic [7:0] halfCnt_r;
  logic [13:0] delayCnt_r;
  logic [15:0] txShift_r;
  logic [15:0] rxShift_r;
  logic atEnd_r;
  logic haltStop_r;
  logic parked_r;
  logic newStart_r;
  logic sck_r;
  logic dout_r;
  logic doutEn_n_r;
  logic [3:0] cs_r;
  logic inMeta_r;
  logic inSync_r;

  logic wrap_enable;
  logic rdEn;
  logic wrMode;
  logic wrDelay;
  logic wrWrap;
  logic wrFlag;
  logic winAccess;
  logic abortNow;
  logic finishNow;
  logic startNow;
  logic lastEdge;
  logic sampleEdge;
  logic shiftOut;
  logic [3:0] nextPtr;
  logic [3:0] loadPtr;

  function automatic logic [4:0] wordBits(qsmc_mode_t m, qsmc_cmd_t c);
    logic [4:0] n;
    n = DEFAULT_BITS;
    if (c.lengthEnable)
    begin
      if (m.wordLength == 4'h0)
        n = FULL_BITS;
      else if (m.wordLength[3])
        n = {1'b0, m.wordLength};
    end
    return n;
  endfunction : wordBits

  function automatic logic [31:0] regRead(logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      MODE_OFS: v = {16'h0000, mode_r};
      DELAY_OFS: v = {16'h0000, delay_r};
      WRAP_OFS: v = {16'h0000, wrap_r};
      FLAG_OFS:
      begin
        v[FINISHED_BIT] = finished_r;
        v[ABORTED_BIT] = aborted_r;
        v[LOCKOUT_BIT] = lockout_r;
      end
      RAMADDR_OFS: v = {26'h0000000, ramAddr_r};
      RAMDATA_OFS:
      begin
        // command section is write-only and reads as zero
        if (ramAddr_r < RX_BASE)
          v = {16'h0000, txRam[ramAddr_r[3:0]]};
        else if (ramAddr_r < CMD_BASE)
          v = {16'h0000, rxRam[ramAddr_r[3:0]]};
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : regRead

  // bus strobes: the data phase is the cycle after the address phase
  assign wrap_enable = pend_r && pendWrite_r;
  assign rdEn = pend_r && !pendWrite_r;
  assign wrMode = wrap_enable && (pendAddr_r == MODE_OFS);
  assign wrDelay = wrap_enable && (pendAddr_r == DELAY_OFS);
  assign wrWrap = wrap_enable && (pendAddr_r == WRAP_OFS);
  assign wrFlag = wrap_enable && (pendAddr_r == FLAG_OFS);
  assign winAccess = pend_r && (pendAddr_r == RAMDATA_OFS);

  assign abortNow = wrDelay && !hwdata[15] && delay_r.runEnable &&
    (state_r != ST_IDLE) && !lockout_r;
  assign finishNow = (state_r == ST_POST) && (delayCnt_r == 14'h0000) &&
    (atEnd_r || haltStop_r);
  assign startNow = (state_r == ST_IDLE) && delay_r.runEnable &&
    (mode_r.clockDivider != 8'h00) && !(parked_r && wrap_r.halt);
  assign lastEdge = (halfCnt_r == 8'h00) &&
    (edgeCnt_r == 5'(({1'b0, bits_r} << 1) - 6'h01));
  assign sampleEdge = mode_r.clockPhase ? edgeCnt_r[0] : !edgeCnt_r[0];
  assign shiftOut = (state_r == ST_SHIFT) && (mode_r.clockDivider != 8'h00) &&
    (halfCnt_r == 8'h00) && !sampleEdge && (edgeCnt_r != 5'h00);
  assign loadPtr = (parked_r ? nextPtr : wrap_r.startPointer);

  always_comb
  begin
    nextPtr = workPtr_r + 4'h1;
    if (newStart_r)
      nextPtr = wrap_r.startPointer;
    else if (workPtr_r == wrap_r.endPointer)
      nextPtr = wrap_r.wrapTarget ? wrap_r.startPointer : 4'h0;
  end

  // ahb-lite slave: one wait state, so read data comes from a flop
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pend_r <= 1'b0;
      pendWrite_r <= 1'b0;
      pendAddr_r <= 12'h000;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h0000_0000;
      hresp_r <= 1'b0;
    end
    else if (pend_r)
    begin
      pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      if (rdEn)
        hrdata_r <= regRead(pendAddr_r);
    end
    else if (hsel && htrans[1] && hready)
    begin
      pend_r <= 1'b1;
      pendWrite_r <= hwrite;
      pendAddr_r <= haddr[ADDR_W-1:0];
      hreadyout_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      mode_r <= qsmc_mode_t'(MODE_RST);
    else if (wrMode)
      mode_r <= qsmc_mode_t'(hwdata[15:0]);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      delay_r <= qsmc_delay_t'(DELAY_RST);
    else
    begin
      if (wrDelay)
      begin
        delay_r.selectToClockDelay <= hwdata[14:8];
        delay_r.postTransferDelay <= hwdata[7:0];
        if (hwdata[15] || !lockout_r || state_r == ST_IDLE)
          delay_r.runEnable <= hwdata[15];
      end
      if (finishNow && atEnd_r && !wrap_r.wrapEnable)
        delay_r.runEnable <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      wrap_r <= qsmc_wrap_t'(WRAP_RST);
    else
    begin
      if (wrWrap)
      begin
        wrap_r.halt <= hwdata[15];
        wrap_r.wrapEnable <= hwdata[14];
        wrap_r.wrapTarget <= hwdata[13];
        wrap_r.selectIdleLevel <= hwdata[12];
        wrap_r.endPointer <= hwdata[11:8];
        wrap_r.startPointer <= hwdata[3:0];
      end
      if (state_r == ST_POST)
        wrap_r.completedPointer <= workPtr_r;
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      finished_r <= 1'b0;
      aborted_r <= 1'b0;
      lockout_r <= 1'b0;
    end
    else
    begin
      if (wrFlag)
        lockout_r <= hwdata[LOCKOUT_BIT];
      if (finishNow || (state_r == ST_POST && delayCnt_r == 14'h0000 &&
          workPtr_r == wrap_r.endPointer))
        finished_r <= 1'b1;
      else if (wrFlag && hwdata[FINISHED_BIT])
        finished_r <= 1'b0;
      if (abortNow)
        aborted_r <= 1'b1;
      else if (wrFlag && hwdata[ABORTED_BIT])
        aborted_r <= 1'b0;
    end
  end

  // indirect ram window; pointer steps on every window access
  always_ff @(posedge clock)
  begin
    if (srst)
      ramAddr_r <= TX_BASE;
    else if (wrap_enable && pendAddr_r == RAMADDR_OFS)
      ramAddr_r <= hwdata[5:0];
    else if (winAccess)
      ramAddr_r <= ramAddr_r + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (wrap_enable && winAccess)
    begin
      if (ramAddr_r < RX_BASE)
        txRam[ramAddr_r[3:0]] <= hwdata[15:0];
      else if (ramAddr_r >= CMD_BASE && ramAddr_r < RAM_TOP)
        cmdRam[ramAddr_r[3:0]] <= qsmc_cmd_t'(hwdata[15:8]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (state_r == ST_POST)
      rxRam[workPtr_r] <= rxShift_r;
  end

  // serial input comes from a pin: two flops before use
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      inMeta_r <= 1'b0;
      inSync_r <= 1'b0;
    end
    else
    begin
      inMeta_r <= serialIn;
      inSync_r <= inMeta_r;
    end
  end

  // queue engine
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= ST_IDLE;
      workPtr_r <= 4'h0;
      cmd_r <= qsmc_cmd_t'(8'h00);
      bits_r <= DEFAULT_BITS;
      edgeCnt_r <= 5'h00;
      halfCnt_r <= 8'h00;
      delayCnt_r <= 14'h0000;
      txShift_r <= 16'h0000;
      rxShift_r <= 16'h0000;
      atEnd_r <= 1'b0;
      haltStop_r <= 1'b0;
      parked_r <= 1'b0;
      newStart_r <= 1'b0;
    end
    else if (abortNow)
    begin
      state_r <= ST_IDLE;
      parked_r <= 1'b0;
      newStart_r <= 1'b0;
    end
    else
    begin
      if (wrWrap && state_r != ST_IDLE)
        newStart_r <= 1'b1;
      if (!delay_r.runEnable)
        parked_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (startNow)
          begin
            workPtr_r <= loadPtr;
            parked_r <= 1'b0;
            newStart_r <= 1'b0;
            state_r <= ST_SELDLY;
          end
        end
        ST_SELDLY:
        begin
          if (delayCnt_r == 14'h0000)
          begin
            state_r <= ST_SHIFT;
            // select delay already spent: first edge comes next cycle
            halfCnt_r <= 8'h00;
            edgeCnt_r <= 5'h00;
          end
          else
            delayCnt_r <= delayCnt_r - 14'h0001;
        end
        ST_SHIFT:
        begin
          if (mode_r.clockDivider == 8'h00)
            halfCnt_r <= halfCnt_r;
          else if (halfCnt_r != 8'h00)
            halfCnt_r <= halfCnt_r - 8'h01;
          else
          begin
            halfCnt_r <= mode_r.clockDivider - 8'h01;
            edgeCnt_r <= edgeCnt_r + 5'h01;
            if (sampleEdge)
              rxShift_r <= {rxShift_r[14:0], inSync_r};
            else if (edgeCnt_r != 5'h00)
              txShift_r <= {txShift_r[14:0], 1'b0};
            if (lastEdge)
            begin
              state_r <= ST_POST;
              atEnd_r <= (workPtr_r == wrap_r.endPointer) &&
                !wrap_r.wrapEnable;
              haltStop_r <= wrap_r.halt;
              if (!cmd_r.postDelayEnable)
                delayCnt_r <= STD_POST_CYCLES - 14'h0001;
              else if (delay_r.postTransferDelay == 8'h00)
                delayCnt_r <= POST_ZERO_W - 14'h0001;
              else
                delayCnt_r <= 14'({6'h00, delay_r.postTransferDelay} <<
                  POST_UNIT_SHIFT) - 14'h0001;
            end
          end
        end
        ST_POST:
        begin
          if (delayCnt_r != 14'h0000)
            delayCnt_r <= delayCnt_r - 14'h0001;
          else if (atEnd_r || haltStop_r)
          begin
            state_r <= ST_IDLE;
            parked_r <= haltStop_r && !atEnd_r;
            workPtr_r <= workPtr_r;
          end
          else
          begin
            workPtr_r <= nextPtr;
            newStart_r <= 1'b0;
            state_r <= ST_SELDLY;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // fetch the command and word as the select delay begins
      if ((state_r == ST_IDLE && startNow) ||
          (state_r == ST_POST && delayCnt_r == 14'h0000 &&
           !atEnd_r && !haltStop_r))
      begin
        cmd_r <= cmdRam[startNow ? loadPtr : nextPtr];
        bits_r <= wordBits(mode_r, cmdRam[startNow ? loadPtr : nextPtr]);
        txShift_r <= txRam[startNow ? loadPtr : nextPtr] <<
          (FULL_BITS - wordBits(mode_r,
            cmdRam[startNow ? loadPtr : nextPtr]));
        rxShift_r <= 16'h0000;
        if (cmdRam[startNow ? loadPtr : nextPtr].selectDelayEnable &&
            delay_r.selectToClockDelay != 7'h00)
          delayCnt_r <= {7'h00, delay_r.selectToClockDelay} -
            14'h0001;
        else
          delayCnt_r <= {6'h00, mode_r.clockDivider} - 14'h0001;
      end
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sck_r <= 1'b0;
      dout_r <= 1'b0;
      doutEn_n_r <= 1'b0;
      cs_r <= 4'h0;
    end
    else
    begin
      if (state_r == ST_SHIFT && halfCnt_r == 8'h00 &&
          mode_r.clockDivider != 8'h00)
        sck_r <= !sck_r;
      else if (state_r != ST_SHIFT)
        sck_r <= mode_r.clockPolarity;
      // take the shifted bit so data moves with the clock edge
      dout_r <= shiftOut ? txShift_r[14] : txShift_r[15];
      doutEn_n_r <= mode_r.outputFloatBetweenWords &&
        (state_r != ST_SHIFT);
      if (state_r == ST_SELDLY || state_r == ST_SHIFT ||
          (state_r == ST_POST && cmd_r.keepSelect &&
           !atEnd_r && !haltStop_r))
        cs_r <= cmd_r.selects;
      else
        cs_r <= {4{wrap_r.selectIdleLevel}};
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign serialClock = sck_r;
  assign serialOut = dout_r;
  assign serialOutEn_n = doutEn_n_r;
  assign chipSelect = cs_r;

endmodule : qsmc_core
`default_nettype wire

/* rtl/qsmc_pkg.sv */
package qsmc_pkg;

  // register byte offsets (low address bits only are decoded)
  localparam int ADDR_W = 12;
  localparam logic [11:0] MODE_OFS = 12'h400;
  localparam logic [11:0] DELAY_OFS = 12'h404;
  localparam logic [11:0] WRAP_OFS = 12'h408;
  localparam logic [11:0] FLAG_OFS = 12'h40c;
  localparam logic [11:0] RAMADDR_OFS = 12'h410;
  localparam logic [11:0] RAMDATA_OFS = 12'h414;

  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] WRAP_RST = 16'h0000;

  // event flag register bit positions
  localparam int FINISHED_BIT = 0;
  localparam int ABORTED_BIT = 2;
  localparam int LOCKOUT_BIT = 12;

  // indirect ram map: transmit, receive, command sections
  localparam logic [5:0] TX_BASE = 6'h00;
  localparam logic [5:0] RX_BASE = 6'h10;
  localparam logic [5:0] CMD_BASE = 6'h20;
  localparam logic [5:0] RAM_TOP = 6'h30;

  // timing in system clocks, and word lengths in bits
  localparam logic [13:0] STD_POST_CYCLES = 14'h0011;
  localparam int POST_UNIT_SHIFT = 5;
  localparam int POST_ZERO_CYCLES = 8192;
  localparam logic [4:0] DEFAULT_BITS = 5'h08;
  localparam logic [4:0] FULL_BITS = 5'h10;

  typedef struct packed {
    logic masterSelect;
    logic outputFloatBetweenWords;
    logic [3:0] wordLength;
    logic clockPolarity;
    logic clockPhase;
    logic [7:0] clockDivider;
  } qsmc_mode_t;

  typedef struct packed {
    logic runEnable;
    logic [6:0] selectToClockDelay;
    logic [7:0] postTransferDelay;
  } qsmc_delay_t;

  typedef struct packed {
    logic halt;
    logic wrapEnable;
    logic wrapTarget;
    logic selectIdleLevel;
    logic [3:0] endPointer;
    logic [3:0] completedPointer;
    logic [3:0] startPointer;
  } qsmc_wrap_t;

  typedef struct packed {
    logic keepSelect;
    logic lengthEnable;
    logic postDelayEnable;
    logic selectDelayEnable;
    logic [3:0] selects;
  } qsmc_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SELDLY = 2'b01,
    ST_SHIFT = 2'b11,
    ST_POST = 2'b10
  } qsmc_state_t;

endpackage : qsmc_pkg

/* verif/qsmc_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module qsmc_core_sva
  import qsmc_pkg::*;
#(
  parameter int POST_ZERO = POST_ZERO_CYCLES
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serialClock,
  input wire logic serialOut,
  input wire logic serialOutEn_n,
  input wire logic serialIn,
  input wire logic [3:0] chipSelect
);
  logic taken;
  logic wPend;
  logic rdPend;
  logic wrNow;
  logic [11:0] wAddr;
  qsmc_mode_t modeR;
  logic csivR;
  logic pol;
  logic flt;
  logic lastClk;
  logic [15:0] halfCnt;
  logic [3:0] idleSel;

  assign taken = hsel & htrans[1] & hready;
  assign wrNow = wPend & ~hreadyout;
  assign idleSel = {4{csivR}};
  assign pol = modeR.clockPolarity;
  assign flt = modeR.outputFloatBetweenWords;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);

  always_ff @(posedge clock)
  begin
    if (srst || (hreadyout && !taken))
    begin
      wPend <= 1'b0;
      rdPend <= 1'b0;
    end
    else if (taken)
    begin
      wPend <= hwrite;
      rdPend <= ~hwrite;
      wAddr <= haddr[11:0];
    end
  end

  // shadows load on the same edge as the design's own registers
  always_ff @(posedge clock)
  begin
    if (srst)
      modeR <= MODE_RST;
    else if (wrNow && wAddr == MODE_OFS)
      modeR <= hwdata[15:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      csivR <= 1'b0;
    else if (wrNow && wAddr == WRAP_OFS)
      csivR <= hwdata[12];
  end

  always_ff @(posedge clock)
  begin
    lastClk <= serialClock;
    if (srst)
      halfCnt <= 16'h0000;
    else if (serialClock != lastClk)
      halfCnt <= 16'h0001;
    else if (halfCnt != 16'hffff)
      halfCnt <= halfCnt + 16'h0001;
  end

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("transfer without exactly one wait state");
  a_wait_cause: assert property (!hreadyout |-> $past(taken))
    else $error("wait state without a transfer");
  a_rd_hold: assert property ($changed(hrdata)
    |-> $rose(hreadyout) && $past(rdPend))
    else $error("read data moved outside a read");
  a_half_period: assert property (
    $changed(serialClock) && chipSelect != idleSel
    && modeR.clockDivider != 8'h00
    |-> halfCnt >= {8'h00, modeR.clockDivider})
    else $error("serial clock half period too short");
  a_idle_clock: assert property (
    chipSelect == idleSel && $stable(chipSelect)
    |-> serialClock == $past(pol))
    else $error("serial clock off its idle level");
  a_out_float: assert property (
    chipSelect == idleSel && $stable(chipSelect)
    |-> serialOutEn_n == $past(flt))
    else $error("data output drive wrong between words");
  a_data_edge: assert property (
    $changed(serialOut) && $stable(chipSelect) && chipSelect != idleSel
    && !modeR.clockPhase && !pol |-> $fell(serialClock))
    else $error("data changed off the falling edge");
endmodule : qsmc_core_sva
`default_nettype wire

/* verif/qsmc_peripheral.sv */
`timescale 1ns/1ps
`default_nettype none
module qsmc_peripheral
(
  input wire logic clock,
  input wire logic serialClock,
  input wire logic dataLine,
  input wire logic picked,
  input wire logic [7:0] reply,
  output logic serialIn,
  output logic [15:0] heard,
  output int halfPeriod
);
  int falls = 0;
  int base = 0;
  int idx;
  int gap = 0;
  logic cur;
  logic held = 1'b0;
  logic lastClk = 1'b0;

  assign idx = falls - base;
  // past the reply byte the line shows the inverse of its last bit
  assign cur = (idx < 8) ? reply[7 - idx] : ~reply[0];
  // a released line never shows the last bit again
  assign serialIn = picked ? cur : ~held;

  always @(posedge picked)
    base <= falls;

  always @(negedge serialClock)
    falls <= falls + 1;

  always @(negedge picked)
    held <= cur;

  always @(posedge serialClock)
    if (picked)
      heard <= {heard[14:0], dataLine};

  always @(posedge clock)
  begin
    lastClk <= serialClock;
    if (serialClock !== lastClk)
    begin
      halfPeriod <= gap;
      gap <= 1;
    end
    else
      gap <= gap + 1;
  end
endmodule : qsmc_peripheral
`default_nettype wire

/* verif/qsmc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qsmc_pkg::*;
;
  localparam logic [15:0] TX0 = 16'h5a9c;
  localparam logic [15:0] TX1 = 16'ha96b;
  logic clock;
  logic srst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic serialClock;
  logic serialOut;
  logic serialOutEn_n;
  logic serialIn;
  logic [3:0] chipSelect;
  logic dataLine;
  logic picked;
  logic [15:0] heard;
  int halfPeriod;
  int errorCnt = 0;
  int nTests = 0;

  assign dataLine = serialOutEn_n ? 1'bz : serialOut;
  assign picked = (chipSelect[0] === 1'b1);

  qsmc_core #(.POST_ZERO(64)) u_dut (.clock(clock), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serialClock(serialClock),
    .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
    .serialIn(serialIn), .chipSelect(chipSelect));

  qsmc_peripheral u_peer (.clock(clock), .serialClock(serialClock),
    .dataLine(dataLine), .picked(picked), .reply(8'hc5),
    .serialIn(serialIn), .heard(heard), .halfPeriod(halfPeriod));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [15:0] wd, output logic [15:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    @(posedge clock);
    while (hreadyout !== 1'b1)
      @(posedge clock);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0000, wd};
    @(posedge clock);
    while (hreadyout !== 1'b1)
      @(posedge clock);
    rd = hrdata[15:0];
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdchk(input string what, input logic [11:0] a,
    input logic [15:0] exp);
    logic [15:0] x;
    bus(1'b0, a, 16'h0000, x);
    chk(what, {16'h0000, exp}, {16'h0000, x});
  endtask : rdchk

  task automatic t_regs;
    rdchk("mode", MODE_OFS, MODE_RST);
    rdchk("delay", DELAY_OFS, DELAY_RST);
    rdchk("wrap", WRAP_OFS, WRAP_RST);
    chk("select idle", 32'h0, chipSelect);
    wr(12'h41c, 16'hffff);
    rdchk("unmapped", 12'h41c, 16'h0000);
    wr(WRAP_OFS, 16'h10f0);
    rdchk("wrap ro field", WRAP_OFS, 16'h1000);
    chk("select idle high", 32'hf, chipSelect);
    wr(MODE_OFS, 16'hc200);
    rdchk("mode rw", MODE_OFS, 16'hc200);
    chk("clock idle high", 32'h1, serialClock);
    chk("output floated", 32'h1, serialOutEn_n);
    wr(MODE_OFS, 16'h8000);
    wr(WRAP_OFS, 16'h0000);
    repeat (2) @(posedge clock);
    chk("clock idle low", 32'h0, serialClock);
    chk("output driven", 32'h0, serialOutEn_n);
    chk("select idle low", 32'h0, chipSelect);
  endtask : t_regs

  task automatic t_queue;
    logic [15:0] v;
    int n;
    wr(RAMADDR_OFS, {10'h000, TX_BASE});
    wr(RAMDATA_OFS, TX0);
    wr(RAMDATA_OFS, TX1);
    wr(RAMADDR_OFS, {10'h000, CMD_BASE});
    wr(RAMDATA_OFS, 16'h0100);
    wr(RAMDATA_OFS, 16'h4100);
    wr(MODE_OFS, 16'ha804);
    wr(WRAP_OFS, 16'h0100);
    wr(FLAG_OFS, 16'h0005);
    wr(DELAY_OFS, 16'h8000);
    n = 0;
    do
    begin
      bus(1'b0, DELAY_OFS, 16'h0000, v);
      n++;
    end
    while (v[15] === 1'b1 && n < 400);
    chk("run cleared", 32'h0, v);
    rdchk("done pointer", WRAP_OFS, 16'h0110);
    rdchk("finished", FLAG_OFS, 16'h0001);
    chk("heard", {TX0[5:0], TX1[9:0]}, heard);
    chk("half period", 32'd4, halfPeriod);
    wr(RAMADDR_OFS, {10'h000, RX_BASE});
    rdchk("rx first", RAMDATA_OFS, 16'h00c5);
    rdchk("rx second", RAMDATA_OFS, 16'h0314);
  endtask : t_queue

  task automatic lead(input logic [15:0] wrap, input logic [15:0] dly,
    input logic [31:0] exp);
    int n;
    wr(WRAP_OFS, wrap);
    wr(DELAY_OFS, dly);
    n = 0;
    while (chipSelect[0] !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (serialClock !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    chk("lead delay", exp, n);
    repeat (120) @(posedge clock);
  endtask : lead

  task automatic t_lead;
    wr(MODE_OFS, 16'h8004);
    wr(RAMADDR_OFS, {10'h000, CMD_BASE + 6'h02});
    wr(RAMDATA_OFS, 16'h1100);
    lead(16'h0000, 16'h8000, 32'd4);
    lead(16'h0202, 16'h8900, 32'd9);
  endtask : t_lead

  task automatic t_abort;
    wr(MODE_OFS, 16'h8020);
    wr(WRAP_OFS, 16'h0000);
    wr(FLAG_OFS, 16'h1005);
    wr(DELAY_OFS, 16'h8000);
    wr(DELAY_OFS, 16'h0000);
    rdchk("locked run", DELAY_OFS, 16'h8000);
    wr(FLAG_OFS, 16'h0000);
    wr(DELAY_OFS, 16'h0000);
    rdchk("aborted", FLAG_OFS, 16'h0004);
    rdchk("run off", DELAY_OFS, 16'h0000);
    chk("select released", 32'h0, chipSelect);
    chk("clock released", 32'h0, serialClock);
    wr(FLAG_OFS, 16'h0004);
  endtask : t_abort

  task automatic t_halt;
    int n;
    wr(MODE_OFS, 16'h8004);
    wr(WRAP_OFS, 16'h6101);
    wr(DELAY_OFS, 16'h8000);
    repeat (300) @(posedge clock);
    rdchk("wrap finished", FLAG_OFS, 16'h0001);
    wr(FLAG_OFS, 16'h0001);
    wr(WRAP_OFS, 16'he101);
    repeat (150) @(posedge clock);
    n = 0;
    repeat (200)
    begin
      @(posedge clock);
      if (serialClock !== 1'b0)
        n++;
    end
    chk("halted clock", 32'h0, n);
    rdchk("halt finished", FLAG_OFS, 16'h0001);
    rdchk("wrap target", WRAP_OFS, 16'he111);
    wr(DELAY_OFS, 16'h0000);
    wr(WRAP_OFS, 16'h0000);
  endtask : t_halt

  initial
  begin
    repeat (5000) @(posedge clock);
    errorCnt++;
    $display("MISMATCH watchdog expected finish seen timeout");
    conclude();
  end

  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_queue();
    t_lead();
    t_abort();
    t_halt();
    conclude();
  end
endmodule : testbench

bind qsmc_core qsmc_core_sva #(.POST_ZERO(POST_ZERO)) u_sva (
  .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .serialClock(serialClock), .serialOut(serialOut),
  .serialOutEn_n(serialOutEn_n), .serialIn(serialIn),
  .chipSelect(chipSelect));
`default_nettype wire
